// ===== logic/pmd_decode.sv
`timescale 1ns/100ps
`include "pmd_cfg.svh"
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module pmd_decode #(
  parameter logic [15:0] FLASH_SIZE = `PMD_FLASH_8K,
  parameter logic [159:0] PART_NUMBER = {8'h50, 8'h4d, 8'h44, 8'h30,
    8'h31, {15{8'hff}}}
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input pmd_pkg::pmd_req_s req,
  input wire logic info_map_en,
  input wire logic [7:0] cal_data [0:63],
  input wire logic [7:0] flash_rdata,
  output logic [12:0] flash_addr,
  output logic flash_rd,
  output logic flash_wr,
  output logic [7:0] flash_wdata,
  output logic [7:0] rdata,
  output logic rvalid,
  output pmd_pkg::pmd_region_e region
);
  // ---------------------------------------------------------------
  // Address classification
  // ---------------------------------------------------------------
  function automatic pmd_pkg::pmd_region_e classify(input logic [15:0] a);
    if (a >= FLASH_SIZE) begin
      classify = pmd_pkg::PMD_REG_UNIMP;
    end else if (a < `PMD_RST_LO) begin
      classify = pmd_pkg::PMD_REG_OPT;
    end else if (a < `PMD_WDT_LO) begin
      classify = pmd_pkg::PMD_REG_RST;
    end else if (a < `PMD_ILL_LO) begin
      classify = pmd_pkg::PMD_REG_WDT;
    end else if (a < `PMD_IRQ_LO) begin
      classify = pmd_pkg::PMD_REG_ILL;
    end else if (a < `PMD_RSV_LO) begin
      classify = pmd_pkg::PMD_REG_IRQ;
    end else if (a < `PMD_OSC_LO) begin
      classify = pmd_pkg::PMD_REG_RSV;
    end else if (a < `PMD_USR_LO) begin
      classify = pmd_pkg::PMD_REG_OSC;
    end else begin
      classify = pmd_pkg::PMD_REG_USR;
    end
  endfunction : classify

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  logic in_info;
  logic in_flash;
  logic rd_info;
  logic rd_unimp;
  logic rd_flash;
  logic [6:0] info_idx;
  logic [7:0] info_rdata;
  pmd_pkg::pmd_region_e region_nxt;
  logic rd_info_r;
  logic rd_unimp_r;
  logic rd_flash_r;
  logic info_hold_r;
  logic unimp_hold_r;
  logic flash_hold_r;
  logic [7:0] info_hold_data_r;

  // Info overlay only exists while software has it mapped in,
  // and it is tested before the Flash bound so it always wins
  assign in_info = info_map_en && (req.addr >= `PMD_INFO_LO);
  // size bound
  // Nothing at or above the Flash size has storage behind it
  assign in_flash = req.addr < FLASH_SIZE;

  // Read kinds are exclusive, so the answer mux needs no priority
  assign rd_info = req.rd && in_info;
  assign rd_unimp = req.rd && !in_info && !in_flash;
  assign rd_flash = req.rd && !in_info && in_flash;

  // Region of the request, reported one cycle later
  always_comb begin
    region_nxt = classify(req.addr);
    if (in_info) begin
      region_nxt = pmd_pkg::PMD_REG_INFO;
    end
  end

  // Region output; it follows the address whether or not a read
  // or write is asked for, so it is a decode view and not a status
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      region <= pmd_pkg::PMD_REG_OPT;
    end else begin
      region <= region_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Flash strobes
  // ---------------------------------------------------------------
  // drop writes
  // info writes dropped
  // Only writes that land in real Flash outside the overlay strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flash_wr <= 1'b0;
    end else begin
      flash_wr <= req.wr && in_flash && !in_info;
    end
  end

  // Read strobe; the array stays idle on fill and overlay reads,
  // which keeps its power down when the core walks the top area
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flash_rd <= 1'b0;
    end else begin
      flash_rd <= rd_flash;
    end
  end

  // Address and data follow the request every cycle; the array
  // ignores them without a strobe, which saves an enable mux
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flash_addr <= 13'h0000;
      flash_wdata <= 8'h00;
    end else begin
      flash_addr <= req.addr[12:0];
      flash_wdata <= req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Information area
  // ---------------------------------------------------------------
  // Addresses with bit 7 set fold onto the last index, which is
  // padding, and ff00-ff7f alias fe00-fe7f, so the store needs only seven index bits
  assign info_idx = req.addr[6:0] | {7{req.addr[7]}};

  pmd_info_rom #(
    .PART_NUMBER(PART_NUMBER)
  ) u_info (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .idx(info_idx),
    .cal_data(cal_data),
    .rdata(info_rdata)
  );

  // ---------------------------------------------------------------
  // Read pipeline
  // ---------------------------------------------------------------
  // Stage one: the kind of read travels beside the flash strobe and
  // beside the registered info byte, so all three kinds stay in
  // step and answers leave in the order the reads came in.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rd_info_r <= 1'b0;
      rd_unimp_r <= 1'b0;
      rd_flash_r <= 1'b0;
    end else begin
      rd_info_r <= rd_info;
      rd_unimp_r <= rd_unimp;
      rd_flash_r <= rd_flash;
    end
  end

  // Stage two: flash data is only valid in the cycle after flash_rd,
  // so every kind waits one more cycle; the cost is a fixed latency
  // of three edges even for reads that never touch the array.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      info_hold_r <= 1'b0;
      unimp_hold_r <= 1'b0;
      flash_hold_r <= 1'b0;
      info_hold_data_r <= 8'h00;
    end else begin
      info_hold_r <= rd_info_r;
      unimp_hold_r <= rd_unimp_r;
      flash_hold_r <= rd_flash_r;
      info_hold_data_r <= info_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Read answer
  // ---------------------------------------------------------------
  // Valid pulse, one cycle per read
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
    end else begin
      rvalid <= info_hold_r | unimp_hold_r | flash_hold_r;
    end
  end

  // Answer byte; it holds its value between answers, so a core
  // that samples late still sees the last byte it asked for
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (info_hold_r) begin
      rdata <= info_hold_data_r;
    end else if (unimp_hold_r) begin
      rdata <= `PMD_FILL;
    end else if (flash_hold_r) begin
      rdata <= flash_rdata;
    end
  end
endmodule : pmd_decode

// ===== logic/pmd_cfg.svh
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH
// Address and data widths
`define PMD_AW 16
`define PMD_DW 8
// Flash size in bytes, 8 KB by default (user space ends at 1fff)
`define PMD_FLASH_8K 16'h2000
`define PMD_FLASH_4K 16'h1000
// Fill value for unimplemented or padded bytes
`define PMD_FILL 8'hff
// Low region boundaries
`define PMD_OPT_LO 16'h0000
`define PMD_RST_LO 16'h0002
`define PMD_WDT_LO 16'h0004
`define PMD_ILL_LO 16'h0006
`define PMD_IRQ_LO 16'h0008
`define PMD_RSV_LO 16'h0038
`define PMD_OSC_LO 16'h003a
`define PMD_USR_LO 16'h003e
// Information area
`define PMD_INFO_LO 16'hfe00
`define PMD_INFO_HI 16'hffff
`define PMD_CAL_HI 16'hfe3f
`define PMD_PN_LO 16'hfe40
`define PMD_PN_HI 16'hfe53
`define PMD_PN_LEN 5'h14
`define PMD_INFO_WORDS 128
`endif

// ===== logic/pmd_pkg.sv
package pmd_pkg;
  // Region of a program memory address
  typedef enum logic [3:0] {
    PMD_REG_OPT = 4'h0,
    PMD_REG_RST = 4'h1,
    PMD_REG_WDT = 4'h2,
    PMD_REG_ILL = 4'h3,
    PMD_REG_IRQ = 4'h4,
    PMD_REG_RSV = 4'h5,
    PMD_REG_OSC = 4'h6,
    PMD_REG_USR = 4'h7,
    PMD_REG_UNIMP = 4'h8,
    PMD_REG_INFO = 4'h9
  } pmd_region_e;

  // Request from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pmd_req_s;
endpackage : pmd_pkg

// ===== logic/pmd_info_rom.sv
`timescale 1ns/100ps
`include "pmd_cfg.svh"
// ---------------------------------------------------------------
// Read-only information area store
// ---------------------------------------------------------------
module pmd_info_rom #(
  parameter logic [159:0] PART_NUMBER = {8'h50, 8'h4d, 8'h44, 8'h30,
    8'h31, {15{8'hff}}}
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [6:0] idx,
  input wire logic [7:0] cal_data [0:63],
  output logic [7:0] rdata
);
  logic [7:0] byte_nxt;
  logic [7:0] pn_i;
  // Contents are constant or strapped; no write port exists
  always_comb begin
    pn_i = 8'h00;
    byte_nxt = `PMD_FILL;
    if (idx < 7'h40) begin
      byte_nxt = cal_data[idx[5:0]];
    end else if (idx < 7'h54) begin
      pn_i = 8'(idx - 7'h40);
      // Part number bytes, first character in the top byte
      byte_nxt = PART_NUMBER[8'd159 - pn_i * 8'd8 -: 8];
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= byte_nxt;
    end
  end
endmodule : pmd_info_rom

// ===== bench/pmd_decode_props.sv
`timescale 1ns/100ps
// ----
// Decode checker
// ----
module pmd_decode_props #(
  parameter logic [15:0] FLASH_SIZE = 16'h2000
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input pmd_pkg::pmd_req_s req,
  input wire logic info_map_en,
  input wire logic flash_rd,
  input wire logic flash_wr,
  input wire logic [12:0] flash_addr,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input pmd_pkg::pmd_region_e region
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Overlay hit and out-of-flash reach of the request
  wire inf = info_map_en && req.addr >= 16'hfe00;
  wire big = req.addr >= FLASH_SIZE;
  // Answers leave three edges after the read is taken
  sequence ans_ff; ##3 rvalid && rdata == 8'hff; endsequence
  AST_UNIMP_FF: assert property (req.rd && big && !inf |-> ans_ff)
    else $error("unimp read");
  AST_WR_DROP: assert property (req.wr && big |=> !flash_wr)
    else $error("write leaked");
  AST_WR_CAUSE: assert property (flash_wr |-> $past(req.wr))
    else $error("stray write");
  AST_RST_VEC: assert property (req.rd && req.addr[15:1] == 15'h1 |=>
    region == pmd_pkg::PMD_REG_RST) else $error("vector region");
  AST_INFO_PAD: assert property (req.rd && inf && req.addr > 16'hfe53 |->
    ans_ff) else $error("info pad");
  AST_INFO_RG: assert property (req.rd && inf |=> region ==
    pmd_pkg::PMD_REG_INFO) else $error("info region");
  AST_ANS: assert property (rvalid |-> $past(req.rd, 3))
    else $error("stray answer");
  AST_WR_PASS: assert property (req.wr && !big |=> flash_wr &&
    flash_addr == $past(req.addr[12:0])) else $error("write lost");
  AST_RD_PASS: assert property (req.rd && !big |=> flash_rd)
    else $error("read lost");
endmodule : pmd_decode_props
bind pmd_decode pmd_decode_props #(.FLASH_SIZE(FLASH_SIZE)) u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .req(req), .info_map_en(info_map_en),
  .flash_rd(flash_rd), .flash_wr(flash_wr), .flash_addr(flash_addr),
  .rdata(rdata), .rvalid(rvalid), .region(region));

// ===== bench/pmd_flash_model.sv
`timescale 1ns/100ps
// ----
// Synchronous flash array
// ----
module pmd_flash_model (
  input wire logic ref_clk,
  input wire logic [12:0] flash_addr,
  input wire logic flash_rd,
  input wire logic flash_wr,
  input wire logic [7:0] flash_wdata,
  output logic [7:0] flash_rdata
);
  logic [7:0] mem [0:8191];
  initial begin
    flash_rdata = 8'h00;
    foreach (mem[i]) mem[i] = i[7:0] ^ 8'h5a;
  end
  // Idle cycles flip the bus so stale data never passes as a read
  always @(posedge ref_clk) begin
    if (flash_wr) mem[flash_addr] <= flash_wdata;
    flash_rdata <= flash_rd ? mem[flash_addr] : ~flash_rdata;
  end
endmodule : pmd_flash_model

// ===== bench/program_memory_map_decode_bench.sv
`timescale 1ns/100ps
// ----
// Decode bench
// ----
module program_memory_map_decode_bench;
  localparam logic [15:0] FS = 16'h2000;
  localparam logic [159:0] PN = {8'h41, 8'h42, {18{8'hff}}};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic info_map_en = 1'b0;
  pmd_pkg::pmd_req_s req = '0;
  logic [7:0] cal [0:63];
  logic [7:0] mir [0:8191];
  logic [7:0] q [$];
  logic [7:0] frd, rdata, fwd, wd;
  logic [12:0] fa;
  logic frd_en, fwr_en, rvalid, m;
  logic [15:0] a;
  logic [15:0] pa;
  logic pm;
  pmd_pkg::pmd_region_e rg;
  int errors = 0;
  int n_checks = 0;
  int op;
  always #50 ref_clk = ~ref_clk;
  pmd_decode #(.FLASH_SIZE(FS), .PART_NUMBER(PN)) dut_u (.ref_clk(ref_clk),
    .reset_n(reset_n), .req(req), .info_map_en(info_map_en),
    .cal_data(cal), .flash_rdata(frd), .flash_addr(fa), .flash_rd(frd_en),
    .flash_wr(fwr_en), .flash_wdata(fwd), .rdata(rdata), .rvalid(rvalid),
    .region(rg));
  pmd_flash_model flash_u (.ref_clk(ref_clk), .flash_addr(fa),
    .flash_rd(frd_en), .flash_wr(fwr_en), .flash_wdata(fwd),
    .flash_rdata(frd));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("errors %0d n_checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  function automatic logic [7:0] exp_rd(input logic [15:0] ad, input logic mp);
    if (mp && ad >= 16'hfe00) begin
      if (ad < 16'hfe40) return cal[ad[5:0]];
      return ad < 16'hfe54 ? PN[159 - 8 * (ad - 16'hfe40) -: 8] : 8'hff;
    end
    return ad < FS ? mir[ad[12:0]] : 8'hff;
  endfunction : exp_rd
  function automatic pmd_pkg::pmd_region_e exp_rg(input logic [15:0] ad,
      input logic mp);
    if (mp && ad >= 16'hfe00) return pmd_pkg::PMD_REG_INFO;
    if (ad >= FS) return pmd_pkg::PMD_REG_UNIMP;
    if (ad < 16'h0002) return pmd_pkg::PMD_REG_OPT;
    if (ad < 16'h0004) return pmd_pkg::PMD_REG_RST;
    if (ad < 16'h0006) return pmd_pkg::PMD_REG_WDT;
    if (ad < 16'h0008) return pmd_pkg::PMD_REG_ILL;
    if (ad < 16'h0038) return pmd_pkg::PMD_REG_IRQ;
    if (ad < 16'h003a) return pmd_pkg::PMD_REG_RSV;
    if (ad < 16'h003e) return pmd_pkg::PMD_REG_OSC;
    return pmd_pkg::PMD_REG_USR;
  endfunction : exp_rg
  // Address and map the design classified at the last rising edge
  always @(posedge ref_clk) begin
    pa <= req.addr;
    pm <= info_map_en;
  end
  // Answers are compared once they have settled
  always @(negedge ref_clk) begin
    if (rvalid === 1'b1) check(rdata, q.pop_front());
    if (reset_n === 1'b1) check(8'(rg), 8'(exp_rg(pa, pm)));
  end
  // Main sequence: back to back traffic near every boundary
  initial begin
    void'($urandom(72));
    foreach (cal[i]) cal[i] = 8'($urandom);
    foreach (mir[i]) mir[i] = i[7:0] ^ 8'h5a;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    // aliased writes above flash must not land
    repeat (800) begin
      @(posedge ref_clk);
      op = $urandom % 3;
      m = 1'($urandom);
      wd = 8'($urandom);
      case ($urandom % 4)
        0: a = 16'($urandom % 64);
        1: a = 16'h1fe0 + 16'($urandom % 64);
        2: a = 16'hfe00 + 16'($urandom % 128);
        default: a = 16'($urandom);
      endcase
      if (op == 2 && a < FS) mir[a[12:0]] = wd;
      if (op == 1) q.push_back(exp_rd(a, m));
      info_map_en <= m;
      req <= '{rd: op == 1, wr: op == 2, addr: a, wdata: wd};
    end
    @(posedge ref_clk) req <= '0;
    repeat (4) @(posedge ref_clk);
    check(8'(q.size()), 8'h00);
    stop_test();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #300000;
    errors++;
    stop_test();
  end
endmodule : program_memory_map_decode_bench
